// File: core/ctrs_dev.sv
// device end: timer, sample-rate, fifo/irq status and identity registers
`timescale 1ns/1ps
`default_nettype none
module ctrs_dev import ctrs_pkg::*; (
	input wire logic sys_clk, // clock
	input wire logic reset_n, // async reset
	ctrs_if.dev bus, // host port
	input wire logic expanded_register_mode, // expanded mode
	input wire logic rate_regs_enable, // rate regs enable
	input wire logic timer_enable_bit, // timer enable
	input wire logic [2:0] legacy_rate_field, // legacy rate code
	input wire logic dac_need, // converter wants sample
	input wire logic dac_empty, // playback fifo empty
	input wire logic pb_wr, // host playback write
	input wire logic pb_full, // playback fifo full
	input wire logic adc_smp, // capture sample ready
	input wire logic cap_full, // capture fifo full
	input wire logic cap_rd, // host capture read
	input wire logic cap_empty, // capture fifo empty
	input wire logic pb_dma_irq, // playback count done
	input wire logic cap_dma_irq, // capture count done
	output logic [15:0] sample_rate_hz, // active rate
	output logic rate_regs_active, // rate regs govern rate
	output logic [2:0] legacy_rate_out, // legacy code in use
	output logic pb_discard, // drop playback write
	output logic cap_drop, // drop capture sample
	output logic cap_repeat, // resend last byte
	output logic irq_out // any pending
);
	typedef struct packed {
		logic [7:0] tmr_lo;
		logic [7:0] tmr_hi;
		logic [7:0] rate_hi;
		logic [7:0] rate_lo;
		logic [15:0] rate;
		logic [15:0] cnt;
		logic [9:0] pre;
		logic [6:0] flags;
		logic [10:0] ti_age;
		logic [7:0] rdata;
		logic ack;
		logic rate_act;
		logic [2:0] legacy;
		logic pdis;
		logic cdrop;
		logic crep;
		logic irq;
	} ctrs_dev_t;
	ctrs_dev_t s_r, s_nxt;
	logic acc, wr, tick;
	always_comb begin
		s_nxt = s_r;
		acc = bus.req && !s_r.ack && !bus.direct && expanded_register_mode;
		wr = acc && bus.wr;
		s_nxt.ack = bus.req && !s_r.ack;
		tick = (s_r.pre == 10'(TICK_DIV - 1));
		s_nxt.pre = tick ? 10'h000 : s_r.pre + 10'h001;
		if (s_r.flags[B_TI] && s_r.ti_age != 11'(TI_HOLD_CYC)) s_nxt.ti_age = s_r.ti_age + 11'h001;
		if (wr) begin
			if (bus.index == IX_TMR_LO) s_nxt.tmr_lo = bus.wdata;
			else if (bus.index == IX_TMR_HI) s_nxt.tmr_hi = bus.wdata;
			else if (bus.index == IX_RATE_HI && rate_regs_enable) s_nxt.rate_hi = bus.wdata;
			else if (bus.index == IX_RATE_LO) begin
				s_nxt.rate_lo = bus.wdata;
				s_nxt.rate = {s_r.rate_hi, bus.wdata};
			end else if (bus.index == IX_STAT) begin
				for (int i = B_PU; i <= B_CI; i++) if (!bus.wdata[i]) s_nxt.flags[i] = 1'b0;
				if (!bus.wdata[B_TI] && s_r.ti_age == 11'(TI_HOLD_CYC)) s_nxt.flags[B_TI] = 1'b0;
			end
		end
		if (bus.req && !s_r.ack && bus.direct && bus.wr) begin
			s_nxt.flags[B_PI] = 1'b0;
			s_nxt.flags[B_CI] = 1'b0;
			s_nxt.flags[B_TI] = 1'b0;
		end
		if (!timer_enable_bit) begin
			s_nxt.flags[B_TI] = 1'b0;
			s_nxt.cnt = {s_r.tmr_hi, s_r.tmr_lo};
		end else if (tick) begin
			if (s_r.cnt == 16'h0000) begin
				s_nxt.flags[B_TI] = 1'b1;
				s_nxt.ti_age = 11'h000;
				s_nxt.cnt = {s_r.tmr_hi, s_r.tmr_lo};
			end else s_nxt.cnt = s_r.cnt - 16'h0001;
		end
		if (dac_need && dac_empty) s_nxt.flags[B_PU] = 1'b1;
		if (pb_wr && pb_full) s_nxt.flags[B_PO] = 1'b1;
		if (adc_smp && cap_full) s_nxt.flags[B_CO] = 1'b1;
		if (cap_rd && cap_empty) s_nxt.flags[B_CU] = 1'b1;
		if (pb_dma_irq) s_nxt.flags[B_PI] = 1'b1;
		if (cap_dma_irq) s_nxt.flags[B_CI] = 1'b1;
		s_nxt.pdis = pb_wr && pb_full;
		s_nxt.cdrop = adc_smp && cap_full;
		s_nxt.crep = cap_rd && cap_empty;
		s_nxt.rate_act = expanded_register_mode && rate_regs_enable;
		s_nxt.legacy = s_nxt.rate_act ? 3'h0 : legacy_rate_field;
		s_nxt.irq = |s_nxt.flags[B_TI:B_PI];
		s_nxt.rdata = 8'h00;
		if (acc && !bus.wr) begin
			if (bus.index == IX_TMR_LO) s_nxt.rdata = s_r.tmr_lo;
			else if (bus.index == IX_TMR_HI) s_nxt.rdata = s_r.tmr_hi;
			else if (bus.index == IX_RATE_HI && rate_regs_enable) s_nxt.rdata = s_r.rate_hi;
			else if (bus.index == IX_RATE_LO) s_nxt.rdata = s_r.rate_lo;
			else if (bus.index == IX_STAT) s_nxt.rdata = {1'b0, s_r.flags};
			else if (bus.index == IX_IDENT) s_nxt.rdata = {VERSION_VAL, 2'b00, CHIP_ID_VAL};
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.rate_hi <= RATE_HI_RST;
			s_r.rate_lo <= RATE_LO_RST;
			s_r.rate <= {RATE_HI_RST, RATE_LO_RST};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign bus.rdata = s_r.rdata;
	assign bus.ack = s_r.ack;
	assign sample_rate_hz = s_r.rate;
	assign rate_regs_active = s_r.rate_act;
	assign legacy_rate_out = s_r.legacy;
	assign pb_discard = s_r.pdis;
	assign cap_drop = s_r.cdrop;
	assign cap_repeat = s_r.crep;
	assign irq_out = s_r.irq;
endmodule : ctrs_dev
`default_nettype wire

// File: core/ctrs_pkg.sv
// package: constants and types shared by the codec timer/rate/status register block
// Functional notes
// - timer reload held at index 20 and 21
// - timer bytes read back written value only
// - tick is clock divided by prescaler
// - rate enable selects rate registers over legacy
// - group reachable only in expanded mode
// - index 22 accessible only with rate enable
// - rate value is hertz, one per LSB
// - host keeps rate within 4 to 50 kHz
// - low rate byte write commits full rate
// - rate resets to 8000 Hz
// - write to full playback FIFO sets overrun
// - capture sample on full FIFO sets overrun
// - empty capture read sets underrun, repeats byte
// - three pending flags playback capture timer
// - direct status write clears all pending
// - zero written clears only that pending bit
// - timer clear needs 10 us; enable clears
// - host writes zero to reserved bits
// - index 25 version and chip ident
package ctrs_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned TICK_DIV = 1000;
	localparam int unsigned TI_HOLD_NS = 10_000;
	localparam int unsigned TI_HOLD_CYC = (TI_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [4:0] IX_TMR_LO = 5'h14;
	localparam logic [4:0] IX_TMR_HI = 5'h15;
	localparam logic [4:0] IX_RATE_HI = 5'h16;
	localparam logic [4:0] IX_RATE_LO = 5'h17;
	localparam logic [4:0] IX_STAT = 5'h18;
	localparam logic [4:0] IX_IDENT = 5'h19;
	localparam logic [7:0] RATE_HI_RST = 8'h1F;
	localparam logic [7:0] RATE_LO_RST = 8'h40;
	localparam int unsigned B_PU = 0;
	localparam int unsigned B_PO = 1;
	localparam int unsigned B_CO = 2;
	localparam int unsigned B_CU = 3;
	localparam int unsigned B_PI = 4;
	localparam int unsigned B_CI = 5;
	localparam int unsigned B_TI = 6;
	localparam logic [2:0] VERSION_VAL = 3'h1; // arbitrary
	localparam logic [2:0] CHIP_ID_VAL = 3'h2; // arbitrary
	localparam logic [1:0] AV_CTRL = 2'h0;
	localparam logic [1:0] AV_DATA = 2'h1;
	localparam logic [1:0] AV_STAT = 2'h2;
	localparam logic [1:0] AV_FLAGS = 2'h3;
	typedef enum logic [1:0] {CT_IDLE, CT_ACT, CT_WAIT, CT_DONE} ctrs_hst_t;
endpackage : ctrs_pkg

// File: core/ctrs_if.sv
// interface: indexed byte-wide register port between host and codec register block
`timescale 1ns/1ps
`default_nettype none
interface ctrs_if;
	logic req;
	logic wr;
	logic direct;
	logic [4:0] index;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	modport dev (input req, wr, direct, index, wdata, output rdata, ack);
	modport hst (output req, wr, direct, index, wdata, input rdata, ack);
endinterface : ctrs_if
`default_nettype wire

// File: core/ctrs_hst.sv
// host end: Avalon-MM slave that forwards single byte accesses to the codec port
`timescale 1ns/1ps
`default_nettype none
module ctrs_hst import ctrs_pkg::*; (
	input wire logic sys_clk, // clock
	input wire logic reset_n, // async reset
	input wire logic [1:0] avs_address, // word address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	ctrs_if.hst bus // codec port
);
	typedef struct packed {
		ctrs_hst_t st;
		logic [4:0] index;
		logic direct;
		logic [7:0] wdata;
		logic [7:0] last;
		logic wr;
		logic req;
		logic wait_n;
		logic [31:0] rd;
	} ctrs_hst_s_t;
	ctrs_hst_s_t s_r, s_nxt;
	always_comb begin
		s_nxt = s_r;
		s_nxt.wait_n = 1'b0;
		case (s_r.st)
			CT_IDLE: begin
				if (avs_write && avs_address == AV_CTRL) begin
					s_nxt.index = avs_writedata[4:0];
					s_nxt.direct = avs_writedata[8];
					s_nxt.wait_n = 1'b1;
					s_nxt.st = CT_DONE;
				end else if (avs_address == AV_DATA && (avs_read || avs_write)) begin
					s_nxt.wr = avs_write;
					s_nxt.wdata = avs_writedata[7:0];
					s_nxt.req = 1'b1;
					s_nxt.st = CT_ACT;
				end else if (avs_read || avs_write) begin
					s_nxt.rd = (avs_address == AV_STAT) ? {24'h000000, s_r.last} :
						{19'h00000, s_r.wr, 3'h0, s_r.direct, 3'h0, s_r.index};
					s_nxt.wait_n = 1'b1;
					s_nxt.st = CT_DONE;
				end
			end
			CT_ACT: begin
				s_nxt.req = 1'b0;
				s_nxt.st = CT_WAIT;
			end
			CT_WAIT: begin
				if (bus.ack) begin
					s_nxt.last = bus.rdata;
					s_nxt.rd = {24'h000000, bus.rdata};
					s_nxt.wait_n = 1'b1;
					s_nxt.st = CT_DONE;
				end
			end
			default: s_nxt.st = CT_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) s_r <= '0;
		else s_r <= s_nxt;
	end
	assign avs_waitrequest = !s_r.wait_n;
	assign avs_readdata = s_r.rd;
	assign bus.req = s_r.req;
	assign bus.wr = s_r.wr;
	assign bus.direct = s_r.direct;
	assign bus.index = s_r.index;
	assign bus.wdata = s_r.wdata;
endmodule : ctrs_hst
`default_nettype wire

// File: sim/ctrs_props.sv
// checker: handshake and readback properties on the codec register port
`timescale 1ns/1ps
`default_nettype none
module ctrs_props import ctrs_pkg::*; (
	input wire logic sys_clk, // clock
	input wire logic reset_n, // async reset
	input wire logic req, // request
	input wire logic wr, // write
	input wire logic direct, // direct status
	input wire logic [4:0] index, // register index
	input wire logic [7:0] wdata, // write byte
	input wire logic [7:0] rdata, // read byte
	input wire logic ack, // answer
	input wire logic expanded_register_mode // expanded mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] t_lo_r;
	logic [7:0] t_hi_r;
	logic rd_ok;
	assign rd_ok = req && !wr && !direct && expanded_register_mode;
	// shadow of the last timer bytes written
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			t_lo_r <= 8'h00;
			t_hi_r <= 8'h00;
		end else if (req && wr && !direct && expanded_register_mode) begin
			if (index == IX_TMR_LO) t_lo_r <= wdata;
			if (index == IX_TMR_HI) t_hi_r <= wdata;
		end
	end
	sequence s_take;
		req ##1 ack;
	endsequence
	sequence s_done;
		ack ##1 !ack;
	endsequence
	req_ack_a: assert property (req |-> s_take) else $error("no answer");
	ack_once_a: assert property (ack |-> s_done) else $error("long answer");
	ack_cause_a: assert property (ack |-> $past(req)) else $error("stray answer");
	ident_read_a: assert property (rd_ok && index == IX_IDENT |=>
		rdata == {VERSION_VAL, 2'h0, CHIP_ID_VAL}) else $error("bad ident");
	stat_res_a: assert property (rd_ok && index == IX_STAT |=> !rdata[7]) else $error("bit7");
	mode_gate_a: assert property (req && !wr && !expanded_register_mode |=>
		rdata == 8'h00) else $error("gated read");
	tmr_lo_a: assert property (rd_ok && index == IX_TMR_LO |=>
		rdata == t_lo_r) else $error("timer low");
	tmr_hi_a: assert property (rd_ok && index == IX_TMR_HI |=>
		rdata == t_hi_r) else $error("timer high");
endmodule : ctrs_props
`default_nettype wire

// File: sim/tb_codec_timer_rate_status_regs.sv
// testbench: host and device joined, Avalon stimulus against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_codec_timer_rate_status_regs import ctrs_pkg::*;;
	logic sys_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [1:0] avs_address = 2'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, rate_regs_active, pb_discard, cap_drop, cap_repeat, irq_out;
	logic expanded_register_mode = 1'b1, rate_regs_enable = 1'b1, timer_enable_bit = 1'b0;
	logic [2:0] legacy_rate_field = 3'h5, legacy_rate_out;
	logic [9:0] ev = 10'h000;
	logic [9:0] em [6] = '{10'h003, 10'h00C, 10'h030, 10'h0C0, 10'h100, 10'h200};
	logic [15:0] sample_rate_hz;
	int error_cnt = 0, cmp_count = 0, seed = 68488, v;
	int mreg [32] = '{default: 0};
	ctrs_if bus_if ();
	always #5 sys_clk = ~sys_clk;
	ctrs_hst ctrs_hst_i (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .bus(bus_if));
	ctrs_dev ctrs_dev_i (.sys_clk, .reset_n, .bus(bus_if), .expanded_register_mode,
		.rate_regs_enable, .timer_enable_bit, .legacy_rate_field, .dac_need(ev[0]),
		.dac_empty(ev[1]), .pb_wr(ev[2]), .pb_full(ev[3]), .adc_smp(ev[4]),
		.cap_full(ev[5]), .cap_rd(ev[6]), .cap_empty(ev[7]), .pb_dma_irq(ev[8]),
		.cap_dma_irq(ev[9]), .sample_rate_hz, .rate_regs_active, .legacy_rate_out,
		.pb_discard, .cap_drop, .cap_repeat, .irq_out);
	ctrs_props ctrs_props_i (.sys_clk, .reset_n, .req(bus_if.req), .wr(bus_if.wr),
		.direct(bus_if.direct), .index(bus_if.index), .wdata(bus_if.wdata),
		.rdata(bus_if.rdata), .ack(bus_if.ack), .expanded_register_mode);
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task av(input logic [1:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	task wi(input logic [4:0] ix, input logic [7:0] b, input logic dr);
		av(2'h0, 1'b1, {23'h0, dr, 3'h0, ix});
		av(2'h1, 1'b1, {24'h0, b});
	endtask : wi
	task ri(input logic [4:0] ix);
		av(2'h0, 1'b1, {27'h0, ix});
		av(2'h1, 1'b0, 32'h0);
	endtask : ri
	task sweep;
		for (int i = 20; i < 27; i++) begin
			ri(i[4:0]);
			chk("reg", mreg[i][7:0], rd[7:0]);
		end
	endtask : sweep
	task pulse(input logic [9:0] m);
		@(posedge sys_clk);
		ev <= m;
		@(posedge sys_clk);
		ev <= 10'h000;
		#1;
	endtask : pulse
	task wrap_up;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#500_000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		mreg[IX_RATE_HI] = RATE_HI_RST;
		mreg[IX_RATE_LO] = RATE_LO_RST;
		mreg[IX_IDENT] = {VERSION_VAL, 2'h0, CHIP_ID_VAL};
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		#1 chk("rate", 16'h1F40, sample_rate_hz);
		sweep();
		ri(IX_IDENT);
		av(AV_STAT, 1'b0, 32'h0);
		chk("last", mreg[IX_IDENT][7:0], rd[7:0]);
		av(AV_FLAGS, 1'b0, 32'h0);
		chk("ctrl", 16'(IX_IDENT), {4'h0, rd[11:0]});
		repeat (2) begin
			v = $random(seed);
			wi(IX_TMR_LO, v[7:0], 1'b0);
			wi(IX_TMR_HI, v[15:8], 1'b0);
			mreg[IX_TMR_LO] = v[7:0];
			mreg[IX_TMR_HI] = v[15:8];
			sweep();
		end
		rate_regs_enable <= 1'b0;
		wi(IX_RATE_HI, 8'h55, 1'b0);
		chk("legacy", 16'h5, {rate_regs_active, legacy_rate_out});
		ri(IX_RATE_HI);
		chk("rate_hi_off", 16'h0, rd[7:0]);
		rate_regs_enable <= 1'b1;
		ri(IX_RATE_HI);
		chk("rate_hi_kept", mreg[IX_RATE_HI][7:0], rd[7:0]);
		v = 4000 + ($unsigned($random(seed)) % 46001);
		wi(IX_RATE_HI, v[15:8], 1'b0);
		chk("hold", 16'h1F40, sample_rate_hz);
		wi(IX_RATE_LO, v[7:0], 1'b0);
		chk("rate", v[15:0], sample_rate_hz);
		chk("active", 16'h8, {rate_regs_active, legacy_rate_out});
		mreg[IX_RATE_HI] = v[15:8];
		mreg[IX_RATE_LO] = v[7:0];
		sweep();
		expanded_register_mode <= 1'b0;
		ri(IX_IDENT);
		chk("gate", 16'h0, rd[7:0]);
		expanded_register_mode <= 1'b1;
		pulse(10'h001);
		for (int i = 0; i < 6; i++) begin
			pulse(em[i]);
			chk("pulse", (i > 0 && i < 4) ? 16'(1 << (i - 1)) : 16'h0,
				{cap_repeat, cap_drop, pb_discard});
			mreg[IX_STAT] |= 1 << i;
			sweep();
		end
		chk("irq", 16'h1, irq_out);
		wi(IX_STAT, 8'h6F, 1'b0);
		mreg[IX_STAT] = 8'h2F;
		sweep();
		wi(5'h00, 8'h00, 1'b1);
		av(AV_FLAGS, 1'b0, 32'h0);
		chk("ctrl", 16'h0100, {4'h0, rd[11:0]});
		mreg[IX_STAT] = 8'h0F;
		sweep();
		chk("irq", 16'h0, irq_out);
		wi(IX_TMR_LO, 8'h02, 1'b0);
		wi(IX_TMR_HI, 8'h00, 1'b0);
		mreg[IX_TMR_LO] = 2;
		mreg[IX_TMR_HI] = 0;
		timer_enable_bit <= 1'b1;
		for (v = 0; v < 8000 && irq_out !== 1'b1; v++) @(posedge sys_clk);
		chk("timer", 16'h1, irq_out);
		chk("period", 16'h1, 16'(v > 2 * TICK_DIV && v <= 3 * TICK_DIV + 1));
		wi(IX_STAT, 8'h0F, 1'b0);
		mreg[IX_STAT] = 8'h4F;
		sweep();
		repeat (TI_HOLD_CYC) @(posedge sys_clk);
		wi(IX_STAT, 8'h0F, 1'b0);
		mreg[IX_STAT] = 8'h0F;
		sweep();
		chk("irq", 16'h0, irq_out);
		for (v = 0; v < 8000 && irq_out !== 1'b1; v++) @(posedge sys_clk);
		chk("reload", 16'h1, irq_out);
		mreg[IX_STAT] = 8'h4F;
		timer_enable_bit <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("te", 16'h0, irq_out);
		mreg[IX_STAT] = 8'h0F;
		sweep();
		wrap_up();
	end
endmodule : tb_codec_timer_rate_status_regs
`default_nettype wire
